/* File: core/charge_status_reporter.sv */
// charger status lamps and single-wire pulse-count reporter
`timescale 1ns/1ps
`default_nettype none

// Operation
// - lamp outputs pull low or float
// - disabled or unknown state: both lamps off
// - no battery: both lamps flash
// - charging A, done B, fault both
// - status line active low, open drain
// - after request rise, delay then reply
// - reply pulses at fixed period
// - one request gives one burst
// - counts 1,2,3 for faults; 4 unused
// - watchdog counts 5, 7, 10
// - counts 6,8,9,11,12 for charge modes
// - over-voltage: fault lamps and count 3
// - battery hot: charging off, count 2
module charge_status_reporter
    import charge_status_pkg::*;
#(
    parameter int REPORT_DELAY = REPORT_DELAY_CYC,
    parameter int PULSE_LOW = PULSE_LOW_CYC,
    parameter int PULSE_PERIOD = PULSE_PERIOD_CYC,
    parameter int FLASH_HALF = FLASH_HALF_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // charger condition
    input wire logic [3:0] chg_state,
    input wire logic [FLT_W-1:0] fault_cause,
    output logic charge_off,
    // lamps, open drain: oe_n low pulls the cathode low
    output logic lamp_out_a_oe_n,
    output logic lamp_out_b_oe_n,
    // status line, open drain
    input wire logic status_in,
    output logic status_out,
    output logic status_oe_n
);
    typedef enum logic [1:0] {
        R_IDLE = 2'b00,
        R_REQ = 2'b01,
        R_WAIT = 2'b10,
        R_BURST = 2'b11
    } rep_state_e;

    rep_state_e state_reg, state_next;
    logic [TMR_W-1:0] tmr_reg, tmr_next;
    logic [4:0] left_reg, left_next;
    logic [TMR_W-1:0] flash_reg;
    logic flash_ph_reg;
    logic lamp_a_n_reg, lamp_b_n_reg, drive_n_reg, off_reg;
    logic line_d_reg;

    wire line_low = !line_d_reg;
    wire req_rise = (state_reg == R_REQ) && !line_low;
    wire req_ok = tmr_reg >= TMR_W'(REQ_MIN_CYC);

    // fault priority follows the report table order
    wire [4:0] fault_cnt = fault_cause[FLT_CHIP_OT] ? CNT_CHIP_OT :
                           fault_cause[FLT_BATT_OT] ? CNT_BATT_OT :
                           fault_cause[FLT_OVP] ? CNT_OVP :
                           fault_cause[FLT_WD_PRE] ? CNT_WD_PRE :
                           fault_cause[FLT_WD_CC] ? CNT_WD_CC :
                           fault_cause[FLT_WD_CV] ? CNT_WD_CV : CNT_ERROR;
    logic [4:0] report_cnt;
    always_comb begin
        case (chg_state)
            ST_FAULT: report_cnt = fault_cnt;
            ST_PRECOND: report_cnt = CNT_PRECOND;
            ST_CC: report_cnt = CNT_CC;
            ST_CC_TLOOP: report_cnt = CNT_CC_TLOOP;
            ST_CV: report_cnt = CNT_CV;
            ST_DONE: report_cnt = CNT_DONE;
            default: report_cnt = CNT_ERROR;
        endcase
    end

    // lamp decode
    wire charging = (chg_state == ST_PRECOND) || (chg_state == ST_CC) ||
                    (chg_state == ST_CC_TLOOP) || (chg_state == ST_CV);
    wire is_fault = (chg_state == ST_FAULT);
    wire no_batt = (chg_state == ST_NO_BATT);
    wire lamp_a_next = charging || is_fault || (no_batt && flash_ph_reg);
    wire lamp_b_next = (chg_state == ST_DONE) || is_fault || (no_batt && flash_ph_reg);
    wire hot = fault_cause[FLT_BATT_OT];
    wire flash_wrap = flash_reg >= TMR_W'(FLASH_HALF - 1);

    always_comb begin
        state_next = state_reg;
        tmr_next = tmr_reg + TMR_W'(1);
        left_next = left_reg;
        case (state_reg)
            R_IDLE: begin
                tmr_next = '0;
                if (line_low) state_next = R_REQ;
            end
            R_REQ: begin
                if (req_rise) begin
                    tmr_next = '0;
                    state_next = req_ok ? R_WAIT : R_IDLE;
                end
            end
            R_WAIT: begin
                if (tmr_reg >= TMR_W'(REPORT_DELAY - 1)) begin
                    tmr_next = '0;
                    left_next = report_cnt;
                    state_next = R_BURST;
                end
            end
            R_BURST: begin
                if (tmr_reg >= TMR_W'(PULSE_PERIOD - 1)) begin
                    tmr_next = '0;
                    left_next = left_reg - 5'h01;
                    if (left_reg == 5'h01) state_next = R_IDLE;
                end
            end
            default: state_next = R_IDLE;
        endcase
    end

    // drive low during the first part of each period of the burst
    wire drive_next = (state_next == R_BURST) && (tmr_next < TMR_W'(PULSE_LOW));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= R_IDLE;
            tmr_reg <= '0;
            left_reg <= '0;
            line_d_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            left_reg <= left_next;
            line_d_reg <= status_in | !drive_n_reg;   // ignore our own pulses
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flash_reg <= '0;
            flash_ph_reg <= 1'b0;
            lamp_a_n_reg <= 1'b1;
            lamp_b_n_reg <= 1'b1;
            drive_n_reg <= 1'b1;
            off_reg <= 1'b1;
        end else begin
            flash_reg <= flash_wrap ? '0 : flash_reg + TMR_W'(1);
            flash_ph_reg <= flash_wrap ? !flash_ph_reg : flash_ph_reg;
            lamp_a_n_reg <= !lamp_a_next;
            lamp_b_n_reg <= !lamp_b_next;
            drive_n_reg <= !drive_next;
            off_reg <= !charging || hot;
        end
    end

    // enables kept inverted in the flops so the pins come straight off them
    assign lamp_out_a_oe_n = lamp_a_n_reg;
    assign lamp_out_b_oe_n = lamp_b_n_reg;
    assign status_out = 1'b0;
    assign status_oe_n = drive_n_reg;
    assign charge_off = off_reg;

    // checks
    a_lamp_fault_both: assert property (@(posedge clk_sys) disable iff (!resetn)
        is_fault |=> !lamp_out_a_oe_n && !lamp_out_b_oe_n)
        else $error("fault lamps not both on");
    a_lamp_disabled_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        chg_state == ST_DISABLED |=> lamp_out_a_oe_n && lamp_out_b_oe_n)
        else $error("lamps on while disabled");
    a_lamp_done_b: assert property (@(posedge clk_sys) disable iff (!resetn)
        chg_state == ST_DONE |=> lamp_out_a_oe_n && !lamp_out_b_oe_n)
        else $error("done pattern wrong");
    a_flash_same: assert property (@(posedge clk_sys) disable iff (!resetn)
        no_batt |=> lamp_out_a_oe_n == lamp_out_b_oe_n)
        else $error("flash lamps out of step");
    a_ovp_count: assert property (@(posedge clk_sys) disable iff (!resetn)
        is_fault && fault_cause[2:0] == 3'b100 |-> report_cnt == CNT_OVP)
        else $error("over-voltage count wrong");
    a_hot_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        hot |=> charge_off)
        else $error("charging not off when battery hot");
    a_count_legal: assert property (@(posedge clk_sys) disable iff (!resetn)
        report_cnt != 5'h04 && report_cnt != 5'h00)
        else $error("illegal reply count");
    sequence s_req_end;
        state_reg == R_REQ && req_rise && req_ok;
    endsequence
    a_delay_then_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_req_end |=> status_oe_n [*2] ##[1:1000] !status_oe_n)
        else $error("reply burst did not start");
    a_no_drive_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_reg == R_IDLE && $past(state_reg) == R_IDLE |-> status_oe_n)
        else $error("line driven outside a burst");
    // run lengths of the line drive, so parameter-set widths can be checked
    logic [TMR_W-1:0] low_run_reg, high_run_reg;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            low_run_reg <= '0;
            high_run_reg <= '0;
        end else begin
            low_run_reg <= status_oe_n ? '0 : low_run_reg + TMR_W'(1);
            high_run_reg <= status_oe_n ? high_run_reg + TMR_W'(1) : '0;
        end
    end
    a_pulse_width: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(status_oe_n) |-> low_run_reg == TMR_W'(PULSE_LOW))
        else $error("reply pulse width wrong");
    a_pulse_period: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(status_oe_n) && $past(state_reg) == R_BURST |->
        high_run_reg == TMR_W'(PULSE_PERIOD - PULSE_LOW))
        else $error("reply pulse spacing wrong");
    sequence s_req_short;
        state_reg == R_REQ && req_rise && !req_ok;
    endsequence
    a_short_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_req_short |=> status_oe_n [*8])
        else $error("short request answered");
    a_lamp_charging: assert property (@(posedge clk_sys) disable iff (!resetn)
        charging |=> !lamp_out_a_oe_n && lamp_out_b_oe_n)
        else $error("charging pattern wrong");
    a_charge_on: assert property (@(posedge clk_sys) disable iff (!resetn)
        charging && !hot |=> !charge_off)
        else $error("charging held off without cause");
endmodule : charge_status_reporter

`default_nettype wire

/* File: core/charge_status_pkg.sv */
// constants for the charger status lamps and pulse-count reporter
package charge_status_pkg;
    // charger states fed in by the charge control
    typedef enum logic [3:0] {
        ST_DISABLED = 4'h0,
        ST_NO_BATT = 4'h1,
        ST_PRECOND = 4'h2,
        ST_CC = 4'h3,
        ST_CC_TLOOP = 4'h4,
        ST_CV = 4'h5,
        ST_DONE = 4'h6,
        ST_FAULT = 4'h7
    } chg_state_e;
    // fault causes, one-hot priority order from bit 0
    localparam int FLT_CHIP_OT = 0;
    localparam int FLT_BATT_OT = 1;
    localparam int FLT_OVP = 2;
    localparam int FLT_WD_PRE = 3;
    localparam int FLT_WD_CC = 4;
    localparam int FLT_WD_CV = 5;
    localparam int FLT_W = 6;
    // reply pulse counts
    localparam logic [4:0] CNT_CHIP_OT = 5'h01;
    localparam logic [4:0] CNT_BATT_OT = 5'h02;
    localparam logic [4:0] CNT_OVP = 5'h03;
    localparam logic [4:0] CNT_WD_PRE = 5'h05;
    localparam logic [4:0] CNT_PRECOND = 5'h06;
    localparam logic [4:0] CNT_WD_CC = 5'h07;
    localparam logic [4:0] CNT_CC_TLOOP = 5'h08;
    localparam logic [4:0] CNT_CC = 5'h09;
    localparam logic [4:0] CNT_WD_CV = 5'h0A;
    localparam logic [4:0] CNT_CV = 5'h0B;
    localparam logic [4:0] CNT_DONE = 5'h0C;
    localparam logic [4:0] CNT_ERROR = 5'h17;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REQ_MIN_NS = 200;
    localparam int REQ_MIN_CYC = (REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REPORT_DELAY_CYC = 100;
    localparam int PULSE_LOW_CYC = 50;
    localparam int PULSE_PERIOD_CYC = 100;
    localparam int FLASH_HALF_CYC = 4000;
    localparam int TMR_W = 24;
endpackage : charge_status_pkg

/* File: verif/status_host_model.sv */
// host that polls the status line and counts reply pulses
`timescale 1ns/1ps
`default_nettype none
module status_host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // control and result
    input wire logic start,
    input wire logic short_req,
    input wire logic line,
    output logic host_low,
    output logic [4:0] got_cnt,
    output logic got_valid
);
    int ph;
    int tmr;
    logic prev;
    logic short_lat;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ph <= 0;
            tmr <= 0;
            prev <= 1'b1;
            short_lat <= 1'b0;
            host_low <= 1'b0;
            got_cnt <= 5'h00;
            got_valid <= 1'b0;
        end else begin
            got_valid <= 1'b0;
            prev <= line;
            tmr <= tmr + 1;
            // 25 cycles clears the 200 ns minimum, far below any sane maximum;
            // 10 cycles falls short on purpose and must be ignored
            if (start) begin
                ph <= 1;
                host_low <= 1'b1;
                tmr <= 0;
                got_cnt <= 5'h00;
                short_lat <= short_req;
            end else if (ph == 1 && tmr == (short_lat ? 9 : 24)) begin
                ph <= 2;
                host_low <= 1'b0;
                tmr <= 0;
            end else if (ph == 2 && prev && !line) begin
                got_cnt <= got_cnt + 5'h01;
                tmr <= 0;
            end else if (ph == 2 && tmr == 40) begin
                ph <= 0;
                got_valid <= 1'b1;
            end
        end
    end
endmodule : status_host_model
`default_nettype wire

/* File: verif/charge_status_reporter_tb.sv */
// bench for the charger lamps and pulse-count reporter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module charge_status_reporter_tb;
    import charge_status_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] chg_state = 4'h0;
    logic [5:0] fault_cause = 6'h00;
    logic start = 1'b0;
    logic short_req = 1'b0;
    logic [4:0] exp_cnt;
    logic charge_off, oe_a_n, oe_b_n, status_out, status_oe_n, host_low, got_valid;
    logic [4:0] got_cnt;
    logic [4:0] expq[$];
    logic [31:0] seed = 32'h00000042;
    int miscompares = 0;
    int checks = 0;
    // pull-up wins unless someone pulls low
    wire logic line = !host_low && (status_oe_n || status_out);
    charge_status_reporter #(.REPORT_DELAY(10), .PULSE_LOW(4), .PULSE_PERIOD(8),
        .FLASH_HALF(16)) uut (.clk_sys(clk_sys), .resetn(resetn), .chg_state(chg_state),
        .fault_cause(fault_cause), .charge_off(charge_off), .lamp_out_a_oe_n(oe_a_n),
        .lamp_out_b_oe_n(oe_b_n), .status_in(line), .status_out(status_out),
        .status_oe_n(status_oe_n));
    status_host_model host (.clk_sys(clk_sys), .resetn(resetn), .start(start),
        .short_req(short_req), .line(line), .host_low(host_low), .got_cnt(got_cnt),
        .got_valid(got_valid));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic [4:0] fault_cnt(input logic [5:0] f);
        logic [4:0] tbl[6] = '{CNT_CHIP_OT, CNT_BATT_OT, CNT_OVP, CNT_WD_PRE, CNT_WD_CC,
            CNT_WD_CV};
        for (int i = 0; i < 6; i++) begin
            if (f[i]) return tbl[i];
        end
        return CNT_ERROR;
    endfunction : fault_cnt
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        if (got_valid === 1'b1) begin
            if (expq.size() == 0) begin
                `CHK("extra burst", 1'b0, 1'b1)
            end else begin
                exp_cnt = expq.pop_front();
                `CHK("count", exp_cnt, got_cnt)
            end
        end
    end
    task automatic lamps(input logic [3:0] s, input logic [5:0] f, input logic [1:0] on);
        @(posedge clk_sys);
        chg_state <= s;
        fault_cause <= f;
        repeat (3) @(negedge clk_sys);
        `CHK("lamps", on, ~{oe_a_n, oe_b_n})
    endtask : lamps
    task automatic report(input logic [3:0] s, input logic [5:0] f, input logic [4:0] n);
        int k;
        @(posedge clk_sys);
        chg_state <= s;
        fault_cause <= f;
        expq.push_back(n);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        k = 0;
        while (got_valid !== 1'b1 && k < 1000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 1000) begin
            miscompares++;
            tally_and_finish();
        end
        @(posedge clk_sys);
    endtask : report
    // a request below the minimum width must bring no pulses at all
    task automatic short_request();
        short_req <= 1'b1;
        report(ST_CC, 6'h00, 5'h00);
        short_req <= 1'b0;
    endtask : short_request
    initial begin
        int tog;
        int apart;
        logic last;
        logic [3:0] st[5] = '{ST_PRECOND, ST_CC, ST_CC_TLOOP, ST_CV, ST_DONE};
        logic [4:0] cn[5] = '{CNT_PRECOND, CNT_CC, CNT_CC_TLOOP, CNT_CV, CNT_DONE};
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        lamps(ST_DISABLED, 6'h00, 2'h0);
        lamps(ST_CC, 6'h00, 2'h2);
        `CHK("charge_off", 1'b0, charge_off)
        lamps(ST_CC, 6'h02, 2'h2);
        `CHK("charge_off", 1'b1, charge_off)
        lamps(ST_DONE, 6'h00, 2'h1);
        lamps(ST_FAULT, 6'h04, 2'h3);
        lamps(ST_FAULT, 6'h02, 2'h3);
        `CHK("charge_off", 1'b1, charge_off)
        $display("lamp states done");
        @(posedge clk_sys);
        chg_state <= ST_NO_BATT;
        tog = 0;
        apart = 0;
        last = 1'b1;
        // flashing lamps must change often and never drift apart
        repeat (80) begin
            @(negedge clk_sys);
            if (oe_a_n !== last) tog++;
            if (oe_a_n !== oe_b_n) apart++;
            last = oe_a_n;
        end
        `CHK("flash toggles", 1'b1, tog >= 3)
        `CHK("flash apart", 0, apart)
        $display("flash done");
        for (int i = 0; i < 6; i++) begin
            report(ST_FAULT, 6'h01 << i, fault_cnt(6'h01 << i));
        end
        for (int i = 0; i < 5; i++) begin
            report(st[i], 6'h00, cn[i]);
        end
        report(4'h8, 6'h00, CNT_ERROR);
        report(ST_FAULT, 6'h00, CNT_ERROR);
        short_request();
        // random cause mixes: lowest set cause wins
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            report(ST_FAULT, seed[5:0], fault_cnt(seed[5:0]));
        end
        $display("reports done");
        tally_and_finish();
    end
endmodule : charge_status_reporter_tb
`default_nettype wire
